/* rtl/codec_interrupt_flags_pin_mux.sv */
// Purpose: Event flag registers and multipurpose pin one function mux
// Assumes: Event sources arrive from other clock domains or the analogue side
// Notes: Register port is a simple strobed address/data port
//
// Notes on behaviour
// - Short-circuit events per driver latch in sticky bits 7..4
// - Button press sets sticky bit 3, zero until a press
// - Either edge of headset presence sets sticky bit 2
// - Noise-gate bits 1 and 0 follow power below threshold in live copy
// - Live flag register mirrors sources other than button bit 3, with the same bit layout
// - Live bit 2 is the present headset level
// - Live button bit latches, cleared only by reading register 14
// - Function field bits 7..4, code 0000 at reset disables the pin
// - Code 0001 puts the converter word clock on the pin
// - Codes 0010..0101 output clock mux divided by 1, 2, 4, 8
// - Code 0110 outputs the short-circuit interrupt
// - Code 1000 makes the pin a general-purpose input
// - Button interrupt stays high until the button is released, starting after delay
// - Code 1101 outputs headset detection interrupt
// - Code 1110 outputs headset OR button interrupt
// - Code 1111 outputs OR of headset, button, short and noise interrupts
// - Bit 3 picks loop clock or divider mux clock
// - Modulator clock code is taken as 1010 and 1011
// - Bit 2 picks single 2 ms pulse or repeats until sticky read
// - Bit 1 reads back the sampled pin level
// - Bit 0 sets the level driven as general-purpose output
`timescale 1ns/1ps
`default_nettype none
module codec_interrupt_flags_pin_mux import codec_irq_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Asynchronous event sources
	input wire logic left_headphone_driver_short,
	input wire logic right_headphone_driver_short,
	input wire logic left_headphone_common_driver_short,
	input wire logic right_headphone_common_driver_short,
	input wire logic button_pressed,
	input wire logic headset_present,
	input wire logic noise_gate_left,
	input wire logic noise_gate_right,
	// Clock sources, same domain as clk, as enables-free levels
	input wire logic loop_clk_level,
	input wire logic divider_clk_level,
	input wire logic word_clk_level,
	input wire logic mod_clk_level,
	// Multipurpose pin one
	input wire logic multipurpose_pin_one_in,
	output logic multipurpose_pin_one_out,
	output logic multipurpose_pin_one_oe
);
	// ********************************
	// Input synchronisers
	// ********************************
	logic [8:0] sync1, sync2, raw_in;
	assign raw_in = {multipurpose_pin_one_in, left_headphone_driver_short,
		right_headphone_driver_short, left_headphone_common_driver_short,
		right_headphone_common_driver_short, button_pressed, headset_present,
		noise_gate_left, noise_gate_right};

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
		end else if (ce) begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	logic pin_level;
	logic [7:0] live_src;
	assign pin_level = sync2[8];
	assign live_src = sync2[7:0];

	// ********************************
	// Edge detection and flags
	// ********************************
	logic [7:0] prev_src, rise, sticky, next_sticky;
	logic btn_live, next_btn_live, hs_edge;
	logic rd_sticky, rd_button;

	function automatic logic reads(input logic rd, input logic [7:0] a, input logic [7:0] t);
		reads = rd && (a == t);
	endfunction

	assign rd_sticky = reads(reg_rd, reg_addr, sticky_event_flags_addr);
	assign rd_button = reads(reg_rd, reg_addr, button_clear_addr);
	assign rise = live_src & ~prev_src;
	assign hs_edge = live_src[headset_bit] ^ prev_src[headset_bit];

	always_comb begin
		next_sticky = rd_sticky ? 8'h00 : sticky;
		next_sticky[short_hi:short_lo] = next_sticky[short_hi:short_lo]
			| rise[short_hi:short_lo];
		next_sticky[button_bit] = next_sticky[button_bit] | rise[button_bit];
		next_sticky[headset_bit] = next_sticky[headset_bit] | hs_edge;
		next_sticky[gate_left_bit] = next_sticky[gate_left_bit] | rise[gate_left_bit];
		next_sticky[gate_right_bit] = next_sticky[gate_right_bit] | rise[gate_right_bit];
		next_btn_live = (rd_button ? 1'b0 : btn_live) | rise[button_bit];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_src <= 8'h00;
			sticky <= 8'h00;
			btn_live <= 1'b0;
		end else if (ce) begin
			prev_src <= live_src;
			sticky <= next_sticky;
			btn_live <= next_btn_live;
		end
	end

	logic [7:0] live_flags;
	always_comb begin
		live_flags = live_src;
		live_flags[button_bit] = btn_live;
	end

	// ********************************
	// Pin control register
	// ********************************
	logic [7:0] pin_ctrl, next_pin_ctrl;
	logic [3:0] func;
	assign func = pin_ctrl[func_hi:func_lo];

	always_comb begin
		next_pin_ctrl = pin_ctrl;
		if (reg_wr && reg_addr == pin_one_function_control_addr) begin
			next_pin_ctrl = reg_wdata;
			next_pin_ctrl[gpi_bit] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			pin_ctrl <= pin_ctrl_reset;
		else if (ce)
			pin_ctrl <= next_pin_ctrl;
	end

	// ********************************
	// Register read
	// ********************************
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				sticky_event_flags_addr: next_rdata = sticky;
				live_event_flags_addr: next_rdata = live_flags;
				pin_one_function_control_addr: begin
					next_rdata = pin_ctrl;
					next_rdata[gpi_bit] = pin_level;
				end
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (ce)
			reg_rdata <= next_rdata;
	end

	// ********************************
	// Clock divider
	// ********************************
	logic mux_clk, prev_mux_clk;
	logic [2:0] div_cnt, next_div_cnt;
	assign mux_clk = pin_ctrl[clk_src_bit] ? divider_clk_level : loop_clk_level;

	always_comb begin
		next_div_cnt = div_cnt;
		if (mux_clk && !prev_mux_clk)
			next_div_cnt = div_cnt + 3'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt <= 3'h0;
			prev_mux_clk <= 1'b0;
		end else if (ce) begin
			div_cnt <= next_div_cnt;
			prev_mux_clk <= mux_clk;
		end
	end

	// ********************************
	// Interrupt shaping
	// ********************************
	logic ev_short, ev_noise, ev_hs, irq_short, irq_noise, irq_hs;
	logic btn_delayed, next_btn_delayed;
	logic [31:0] btn_cnt, next_btn_cnt;
	assign ev_short = |rise[short_hi:short_lo];
	assign ev_noise = rise[gate_left_bit] | rise[gate_right_bit];
	assign ev_hs = hs_edge;

	// Button line goes high after the delay and falls one cycle after release
	always_comb begin
		next_btn_cnt = btn_cnt;
		next_btn_delayed = btn_delayed;
		if (!live_src[button_bit]) begin
			next_btn_cnt = 32'h0;
			next_btn_delayed = 1'b0;
		end else if (btn_cnt == 32'(btn_delay_cycles - 1)) begin
			next_btn_delayed = 1'b1;
		end else begin
			next_btn_cnt = btn_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			btn_cnt <= 32'h0;
			btn_delayed <= 1'b0;
		end else if (ce) begin
			btn_cnt <= next_btn_cnt;
			btn_delayed <= next_btn_delayed;
		end
	end

	logic [2:0] shaped;
	logic [2:0] ev_vec;
	assign ev_vec = {ev_short, ev_noise, ev_hs};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_shape
			pulse_shaper #(.pulse_len(pulse_cycles)) u_shape (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.event_in(ev_vec[i]),
				.repeat_mode(pin_ctrl[pulse_form_bit]),
				.stop(rd_sticky),
				.pulse_out(shaped[i])
			);
		end
	endgenerate
	assign {irq_short, irq_noise, irq_hs} = shaped;

	// ********************************
	// Pin output mux
	// ********************************
	logic next_pin_out, next_pin_oe;
	always_comb begin
		next_pin_out = 1'b0;
		next_pin_oe = 1'b1;
		case (func)
			fn_off: next_pin_oe = 1'b0;
			fn_word_clk: next_pin_out = word_clk_level;
			fn_div1: next_pin_out = mux_clk;
			fn_div2: next_pin_out = div_cnt[0];
			fn_div4: next_pin_out = div_cnt[1];
			fn_div8: next_pin_out = div_cnt[2];
			fn_short, fn_short_b: next_pin_out = irq_short;
			fn_gp_in: next_pin_oe = 1'b0;
			fn_gp_out: next_pin_out = pin_ctrl[gpo_bit];
			fn_mod_clk, fn_mod_clk_b: next_pin_out = mod_clk_level;
			fn_button: next_pin_out = btn_delayed;
			fn_headset: next_pin_out = irq_hs;
			fn_hs_btn: next_pin_out = irq_hs | btn_delayed;
			fn_all: next_pin_out = irq_hs | btn_delayed | irq_short | irq_noise;
			default: next_pin_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			multipurpose_pin_one_out <= 1'b0;
			multipurpose_pin_one_oe <= 1'b0;
		end else if (ce) begin
			multipurpose_pin_one_out <= next_pin_out;
			multipurpose_pin_one_oe <= next_pin_oe;
		end
	end

	// ********************************
	// Checks
	// ********************************
	property p_short_latch;
		@(posedge clk) disable iff (rst)
		(ce && rise[short_hi]) |=> sticky[short_hi];
	endproperty
	a_short_latch: assert property (p_short_latch) else $error("short flag not latched");

	property p_button_set;
		@(posedge clk) disable iff (rst)
		(ce && rise[button_bit]) |=> (sticky[button_bit] && btn_live);
	endproperty
	a_button_set: assert property (p_button_set) else $error("button flag not set");

	property p_headset_edge;
		@(posedge clk) disable iff (rst)
		(ce && $fell(live_src[headset_bit])) |=> sticky[headset_bit];
	endproperty
	a_headset_edge: assert property (p_headset_edge) else $error("removal not flagged");

	property p_sticky_clear;
		@(posedge clk) disable iff (rst)
		(ce && rd_sticky && rise == 8'h00 && !hs_edge) |=> (sticky == 8'h00);
	endproperty
	a_sticky_clear: assert property (p_sticky_clear) else $error("read did not clear");

	property p_btn_hold;
		@(posedge clk) disable iff (rst)
		(ce && btn_live && !rd_button) |=> btn_live;
	endproperty
	a_btn_hold: assert property (p_btn_hold) else $error("live button dropped");

	property p_disabled;
		@(posedge clk) disable iff (rst)
		(ce && func == fn_off) |=> !multipurpose_pin_one_oe;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pin driven while off");

	property p_gpo;
		@(posedge clk) disable iff (rst)
		(ce && func == fn_gp_out) |=> (multipurpose_pin_one_out == $past(pin_ctrl[gpo_bit]));
	endproperty
	a_gpo: assert property (p_gpo) else $error("output level wrong");

	property p_all_or;
		@(posedge clk) disable iff (rst)
		(ce && func == fn_all && irq_short) |=> multipurpose_pin_one_out;
	endproperty
	a_all_or: assert property (p_all_or) else $error("combined irq missing");
endmodule
`default_nettype wire

/* rtl/codec_irq_pkg.sv */
// Purpose: Constants for the codec event flags and multipurpose pin one mux
// Assumes: 100 MHz core clock, 8-bit register port
// Notes: Offsets are the page 0 register numbers in hex
package codec_irq_pkg;
	localparam logic [7:0] sticky_event_flags_addr = 8'h60;
	localparam logic [7:0] live_event_flags_addr = 8'h61;
	localparam logic [7:0] pin_one_function_control_addr = 8'h62;
	localparam logic [7:0] button_clear_addr = 8'h0e;
	localparam logic [7:0] pin_ctrl_reset = 8'h00;
	// Field positions
	localparam int short_hi = 7;
	localparam int short_lo = 4;
	localparam int button_bit = 3;
	localparam int headset_bit = 2;
	localparam int gate_left_bit = 1;
	localparam int gate_right_bit = 0;
	localparam int func_hi = 7;
	localparam int func_lo = 4;
	localparam int clk_src_bit = 3;
	localparam int pulse_form_bit = 2;
	localparam int gpi_bit = 1;
	localparam int gpo_bit = 0;
	// Function codes
	localparam logic [3:0] fn_off = 4'h0;
	localparam logic [3:0] fn_word_clk = 4'h1;
	localparam logic [3:0] fn_div1 = 4'h2;
	localparam logic [3:0] fn_div2 = 4'h3;
	localparam logic [3:0] fn_div4 = 4'h4;
	localparam logic [3:0] fn_div8 = 4'h5;
	localparam logic [3:0] fn_short = 4'h6;
	localparam logic [3:0] fn_short_b = 4'h7;
	localparam logic [3:0] fn_gp_in = 4'h8;
	localparam logic [3:0] fn_gp_out = 4'h9;
	localparam logic [3:0] fn_mod_clk = 4'ha;
	localparam logic [3:0] fn_mod_clk_b = 4'hb;
	localparam logic [3:0] fn_button = 4'hc;
	localparam logic [3:0] fn_headset = 4'hd;
	localparam logic [3:0] fn_hs_btn = 4'he;
	localparam logic [3:0] fn_all = 4'hf;
	// Timing
	localparam int clk_mhz = 100;
	localparam int pulse_us = 2000;
	localparam int pulse_cycles = pulse_us * clk_mhz;
	localparam int btn_delay_us = 500;
	localparam int btn_delay_cycles = btn_delay_us * clk_mhz;
	localparam int repeat_gap_cycles = pulse_cycles;
endpackage

/* rtl/pulse_shaper.sv */
// Purpose: Turns an event into a single or repeating interrupt pulse
// Assumes: Event is a one-cycle pulse on clk
// Notes: Repeat mode runs until the sticky flags are read
`timescale 1ns/1ps
`default_nettype none
module pulse_shaper import codec_irq_pkg::*; #(
	parameter int pulse_len = pulse_cycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Control
	input wire logic event_in,
	input wire logic repeat_mode,
	input wire logic stop,
	// Result
	output logic pulse_out
);
	typedef enum logic [1:0] {idle, high, low} shape_e;
	shape_e state, next_state;
	logic [31:0] count, next_count;

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			idle: begin
				if (event_in) begin
					next_state = high;
					next_count = 32'(pulse_len - 1);
				end
			end
			high: begin
				if (count == 32'h0) begin
					next_state = repeat_mode ? low : idle;
					next_count = 32'(pulse_len - 1);
				end else begin
					next_count = count - 32'h1;
				end
			end
			low: begin
				if (count == 32'h0) begin
					next_state = high;
					next_count = 32'(pulse_len - 1);
				end else begin
					next_count = count - 32'h1;
				end
			end
			default: next_state = idle;
		endcase
		if (stop && !event_in && state != idle && repeat_mode)
			next_state = idle;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= idle;
			count <= 32'h0;
		end else if (ce) begin
			state <= next_state;
			count <= next_count;
		end
	end

	assign pulse_out = (state == high);

	property p_pulse_starts;
		@(posedge clk) disable iff (rst)
		(ce && state == idle && event_in) |=> pulse_out;
	endproperty
	a_pulse_starts: assert property (p_pulse_starts) else $error("pulse did not start");

	property p_single_ends;
		@(posedge clk) disable iff (rst)
		(ce && state == high && count == 32'h0 && !repeat_mode && !event_in) |=> !pulse_out;
	endproperty
	a_single_ends: assert property (p_single_ends) else $error("single pulse overran");
endmodule
`default_nettype wire

/* dv/pin_partner.sv */
// Purpose: Far side of multipurpose pin one, an external driver on the pin
// Assumes: Pin has no pull resistor
// Notes: An undriven pin toggles every cycle so stale levels never pass
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// Clock
	input wire logic clk,
	// Device side
	input wire logic pin_oe,
	input wire logic pin_out,
	// Outside driver
	input wire logic ext_en,
	input wire logic ext_level,
	// Resolved wire
	output logic pin_level
);
	logic filler = 1'b0;
	always_ff @(posedge clk) begin
		filler <= ~filler;
	end
	always_comb begin
		if (pin_oe) begin
			pin_level = pin_out;
		end else if (ext_en) begin
			pin_level = ext_level;
		end else begin
			pin_level = filler;
		end
	end
endmodule
`default_nettype wire

/* dv/codec_interrupt_flags_pin_mux_test.sv */
// Purpose: Self-checking bench for the event flags and pin one mux
// Assumes: Inputs driven on the falling edge, 100 MHz clock
// Notes: Pin pulse lengths of 2 ms are not waited out; only the rise and the repeat stop on a sticky read are seen
`timescale 1ns/1ps
`default_nettype none
module codec_interrupt_flags_pin_mux_test;
	import codec_irq_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
	logic [3:0] sc = 4'h0;
	logic btn = 1'b0, hs = 1'b0, ngl = 1'b0, ngr = 1'b0;
	logic lclk = 1'b0, dclk = 1'b0, wclk = 1'b0, mclk = 1'b0;
	// Pin held low from outside until the GPIO scenario, so read-back bit 1 is known
	logic ext_en = 1'b1, ext_level = 1'b0, pin_level, pin_out, pin_oe;
	int num_errors = 0, n_checks = 0;
	// ************
	// Design and pin
	// ************
	codec_interrupt_flags_pin_mux codec_interrupt_flags_pin_mux_i (
		.clk(clk), .rst(rst), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.left_headphone_driver_short(sc[3]), .right_headphone_driver_short(sc[2]),
		.left_headphone_common_driver_short(sc[1]),
		.right_headphone_common_driver_short(sc[0]),
		.button_pressed(btn), .headset_present(hs),
		.noise_gate_left(ngl), .noise_gate_right(ngr),
		.loop_clk_level(lclk), .divider_clk_level(dclk),
		.word_clk_level(wclk), .mod_clk_level(mclk),
		.multipurpose_pin_one_in(pin_level),
		.multipurpose_pin_one_out(pin_out), .multipurpose_pin_one_oe(pin_oe)
	);
	pin_partner pin_partner_i (
		.clk(clk), .pin_oe(pin_oe), .pin_out(pin_out),
		.ext_en(ext_en), .ext_level(ext_level), .pin_level(pin_level)
	);
	initial begin
		forever #5 clk = ~clk;
	end
	// ************
	// Helpers
	// ************
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rdata", reg_rdata, exp);
	endtask
	task automatic do_reset(input int n);
		@(negedge clk);
		rst = 1'b1;
		cyc(n);
		rst = 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ************
	// Scenarios
	// ************
	task automatic t_reset_values;
		rd(sticky_event_flags_addr, 8'h00);
		rd(live_event_flags_addr, 8'h00);
		rd(pin_one_function_control_addr, 8'h00);
		rd(8'h33, 8'h00);
		chk("pin_oe", {7'h00, pin_oe}, 8'h00);
	endtask
	task automatic t_shorts;
		for (int i = 0; i < 4; i++) begin
			sc = 4'h1 << i;
			cyc(6);
			rd(live_event_flags_addr, {sc, 4'h0});
			sc = 4'h0;
			cyc(6);
			rd(live_event_flags_addr, 8'h00);
			rd(sticky_event_flags_addr, 8'h10 << i);
			rd(sticky_event_flags_addr, 8'h00);
		end
	endtask
	task automatic t_headset;
		hs = 1'b1;
		cyc(6);
		rd(live_event_flags_addr, 8'h04);
		rd(sticky_event_flags_addr, 8'h04);
		rd(sticky_event_flags_addr, 8'h00);
		hs = 1'b0;
		cyc(6);
		rd(live_event_flags_addr, 8'h00);
		rd(sticky_event_flags_addr, 8'h04);
	endtask
	task automatic t_gate;
		ngl = 1'b1;
		cyc(6);
		rd(live_event_flags_addr, 8'h02);
		ngl = 1'b0;
		ngr = 1'b1;
		cyc(6);
		rd(live_event_flags_addr, 8'h01);
		ngr = 1'b0;
		cyc(6);
		rd(live_event_flags_addr, 8'h00);
		rd(sticky_event_flags_addr, 8'h03);
	endtask
	task automatic t_button;
		btn = 1'b1;
		cyc(6);
		rd(sticky_event_flags_addr, 8'h08);
		btn = 1'b0;
		cyc(6);
		rd(live_event_flags_addr, 8'h08);
		rd(sticky_event_flags_addr, 8'h00);
		rd(live_event_flags_addr, 8'h08);
		rd(button_clear_addr, 8'h00);
		rd(live_event_flags_addr, 8'h00);
	endtask
	task automatic t_gpio;
		wr(pin_one_function_control_addr, 8'h91);
		cyc(3);
		chk("pin out oe", {6'h00, pin_oe, pin_out}, 8'h03);
		wr(pin_one_function_control_addr, 8'h90);
		cyc(3);
		chk("pin out oe", {6'h00, pin_oe, pin_out}, 8'h02);
		ext_en = 1'b1;
		ext_level = 1'b1;
		wr(pin_one_function_control_addr, 8'h80);
		cyc(5);
		chk("pin_oe", {7'h00, pin_oe}, 8'h00);
		rd(pin_one_function_control_addr, 8'h82);
		ext_level = 1'b0;
		wr(pin_one_function_control_addr, 8'h82);
		cyc(5);
		rd(pin_one_function_control_addr, 8'h80);
		ext_en = 1'b0;
	endtask
	task automatic t_clocks;
		logic [7:0] codes [5] = '{8'h10, 8'h20, 8'h28, 8'ha0, 8'hb0};
		logic p;
		for (int ph = 0; ph < 2; ph++) begin
			p = ph[0];
			lclk = p;
			dclk = ~p;
			wclk = p;
			mclk = ~p;
			for (int k = 0; k < 5; k++) begin
				wr(pin_one_function_control_addr, codes[k]);
				cyc(4);
				// Word and loop clocks follow p, divider and modulator follow ~p
				chk("pin out oe", {6'h00, pin_oe, pin_out},
					{6'h00, 1'b1, (k == 0 || k == 1) ? p : ~p});
			end
		end
		wr(pin_one_function_control_addr, 8'h00);
		cyc(3);
		chk("pin_oe", {7'h00, pin_oe}, 8'h00);
	endtask
	task automatic t_irq(input logic [3:0] code, input int src);
		int n;
		do_reset(2);
		wr(pin_one_function_control_addr, {code, 4'h0});
		cyc(2);
		chk("pin idle", {7'h00, pin_out}, 8'h00);
		case (src)
			0: sc = 4'h8;
			1: hs = 1'b1;
			default: ngl = 1'b1;
		endcase
		n = 0;
		while (pin_out !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk("pin irq", {6'h00, pin_oe, pin_out}, 8'h03);
		sc = 4'h0;
		hs = 1'b0;
		ngl = 1'b0;
		cyc(6);
	endtask
	task automatic t_freeze;
		ce = 1'b0;
		sc = 4'h8;
		cyc(6);
		sc = 4'h0;
		cyc(2);
		ce = 1'b1;
		cyc(4);
		// A source pulse that falls wholly inside a frozen span is never seen
		rd(sticky_event_flags_addr, 8'h00);
	endtask
	task automatic t_divide;
		lclk = 1'b0;
		do_reset(2);
		for (int e = 1; e < 9; e++) begin
			lclk = 1'b1;
			cyc(1);
			lclk = 1'b0;
			for (int k = 0; k < 3; k++) begin
				wr(pin_one_function_control_addr, {fn_div2 + 4'(k), 4'h0});
				cyc(2);
				// Divide by 2, 4 and 8 toggle every 1, 2 and 4 mux clock rises
				chk("pin divided", {6'h00, pin_oe, pin_out}, {6'h00, 1'b1, e[k]});
			end
		end
	endtask
	task automatic t_repeat;
		do_reset(2);
		wr(pin_one_function_control_addr, {fn_short, 4'h4});
		sc = 4'h8;
		cyc(8);
		chk("pin repeat", {6'h00, pin_oe, pin_out}, 8'h03);
		sc = 4'h0;
		cyc(4);
		rd(sticky_event_flags_addr, 8'h80);
		cyc(3);
		chk("pin stopped", {6'h00, pin_oe, pin_out}, 8'h02);
	endtask
	task automatic t_btn_irq;
		int n;
		do_reset(2);
		wr(pin_one_function_control_addr, {fn_button, 4'h0});
		btn = 1'b1;
		cyc(btn_delay_cycles - 4);
		chk("pin early", {6'h00, pin_oe, pin_out}, 8'h02);
		n = 0;
		while (pin_out !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk("pin button", {6'h00, pin_oe, pin_out}, 8'h03);
		btn = 1'b0;
		cyc(6);
		chk("pin release", {6'h00, pin_oe, pin_out}, 8'h02);
	endtask
	// ************
	// Main sequence
	// ************
	initial begin
		cyc(12);
		rst = 1'b0;
		t_reset_values();
		t_shorts();
		t_headset();
		t_gate();
		t_button();
		t_freeze();
		t_gpio();
		t_clocks();
		t_irq(fn_short, 0);
		t_irq(fn_short_b, 0);
		t_irq(fn_headset, 1);
		t_irq(fn_hs_btn, 1);
		t_irq(fn_all, 0);
		t_irq(fn_all, 2);
		t_divide();
		t_repeat();
		t_btn_irq();
		summarize();
	end
	// Watchdog well beyond the 50.5k cycles the scenarios need, mostly the button delay
	initial begin
		#700000;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
